/* common/cisr_pkg.sv */
package cisr_pkg;

	// ---------------------------------------------------------------
	// Idle state encoding
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		CISR_C0  = 4'h0,
		CISR_C1  = 4'h1,
		CISR_C3  = 4'h3,
		CISR_C6  = 4'h6,
		CISR_C7  = 4'h7,
		CISR_C8  = 4'h8,
		CISR_C9  = 4'h9,
		CISR_C10 = 4'ha
	} cisr_cstate_t;

	// ---------------------------------------------------------------
	// Core sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		CISR_SQ_RUN    = 3'b000,
		CISR_SQ_FLUSH  = 3'b001,
		CISR_SQ_SAVE   = 3'b010,
		CISR_SQ_SLEEP  = 3'b011,
		CISR_SQ_PWRUP  = 3'b100,
		CISR_SQ_RESTOR = 3'b101
	} cisr_seq_t;

	typedef enum logic [1:0] {
		CISR_PS_IDLE = 2'b00,
		CISR_PS_VOLT = 2'b01,
		CISR_PS_LOCK = 2'b10
	} cisr_pst_t;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [3:0]  CISR_REG_CFG     = 4'h0;
	localparam logic [3:0]  CISR_REG_CAP_LO  = 4'h1;
	localparam logic [3:0]  CISR_REG_CAP_HI  = 4'h2;
	localparam logic [3:0]  CISR_REG_PREQ    = 4'h3;
	localparam logic [3:0]  CISR_REG_STATUS  = 4'h4;
	localparam logic [3:0]  CISR_REG_PSTATUS = 4'h5;
	localparam logic [3:0]  CISR_REG_DEMOTE  = 4'h6;

	localparam int CISR_CFG_REDIR  = 0;
	localparam int CISR_CFG_DEM3   = 1;
	localparam int CISR_CFG_DEM1   = 2;
	localparam int CISR_CFG_BRKIF  = 3;

	localparam logic [31:0] CISR_CFG_RST     = 32'h0000_0009;
	localparam logic [15:0] CISR_CAP_LO_RST  = 16'h0000;
	localparam logic [15:0] CISR_CAP_HI_RST  = 16'h0000;
	localparam logic [7:0]  CISR_DEM3_RST    = 8'h04;
	localparam logic [7:0]  CISR_DEM1_RST    = 8'h08;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CISR_CLK_MHZ       = 25;
	localparam int CISR_RESID_WIN_NS  = 10000;
	localparam int CISR_RESID_WIN_CYC = (CISR_RESID_WIN_NS * CISR_CLK_MHZ) / 1000;
	localparam int CISR_ACK_TO_CYC    = 1;

	// ---------------------------------------------------------------
	// Per-thread request carrier
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       wait_req;
		logic [3:0] wait_level;
		logic       halt_req;
		logic       io_rd;
		logic [15:0] io_addr;
	} cisr_treq_t;

endpackage : cisr_pkg

/* hw/cisr_core_idle_state_resolver.sv */
`timescale 1ns/1ns
// Summary of operation
// - Core idle state is the lowest state requested by its threads.
// - Any thread in C0 forces its core to C0.
// - Interrupt, monitor hit or timed deadline returns core to C0.
// - Thread interrupt wakes that thread; package interrupt may wake any core.
// - System reset reinitializes every core.
// - Moving between two non-C0 states requires passing through C0.
// - Power actions start only after the core state is resolved.
// - Active cores share the highest requested performance state.
// - Performance requests always accepted, held until current transition completes.
// - Voltage settles first, then PLL locks; voltage target stepped, settling reported by volt_ok_in.
// - With redirection enabled, legacy idle reads become wait requests, no I/O cycle.
// - Only legacy reads inside the capture range are trapped.
// - Redirected sub-state is zero; wake on interrupt even when masked.
// - Core enters C1 once all threads halt or wait for C1.
// - Snoops are still serviced while a core is in C1.
// - C3 flushes caches to L3, keeps state, then stops core clocks.
// - Snoops and cacheable accesses do not wake a core in C3.
// - C6 saves state to SRAM, removes voltage; exit powers up then restores.
// - Legacy levels four to seven map to C7 through C10.
// - C7 to C10 behave exactly like C6.
// - Optional demotion of deep requests to C3 or C1 from interrupt rate.
// - Demotion is off after reset until firmware enables it.
module cisr_core_idle_state_resolver
	import cisr_pkg::*;
#(
	parameter int NCORE = 2,
	parameter int NTHR  = 2,
	parameter int PW    = 4
) (
	input  wire logic                       core_clk_in,
	input  wire logic                       arst_n_in,
	input  wire cisr_treq_t [NCORE*NTHR-1:0] treq_in,
	input  wire logic [NCORE*NTHR-1:0]      thr_irq_in,
	input  wire logic [NCORE*NTHR-1:0]      thr_irq_masked_in,
	input  wire logic [NCORE*NTHR-1:0]      monitor_hit_in,
	input  wire logic [NCORE*NTHR-1:0]      deadline_in,
	input  wire logic                       pkg_irq_in,
	input  wire logic [NCORE-1:0]           snoop_in,
	input  wire logic [NCORE-1:0]           flush_done_in,
	input  wire logic [NCORE-1:0]           save_done_in,
	input  wire logic [NCORE-1:0]           pwr_good_in,
	input  wire logic [NCORE-1:0]           restore_done_in,
	input  wire logic                       volt_ok_in,
	input  wire logic                       pll_lock_in,
	input  wire logic [3:0]                 reg_addr_in,
	input  wire logic [31:0]                reg_wdata_in,
	input  wire logic                       reg_wr_in,
	input  wire logic                       reg_rd_in,
	output logic [31:0]                     reg_rdata_out,
	output logic [NCORE*NTHR-1:0]           io_pass_out,
	output logic [NCORE*NTHR-1:0]           thr_wake_out,
	output logic [NCORE*4-1:0]              core_state_out,
	output logic [NCORE-1:0]                flush_req_out,
	output logic [NCORE-1:0]                save_req_out,
	output logic [NCORE-1:0]                restore_req_out,
	output logic [NCORE-1:0]                clk_stop_out,
	output logic [NCORE-1:0]                pwr_off_out,
	output logic [NCORE-1:0]                snoop_ack_out,
	output logic [PW-1:0]                   volt_target_out,
	output logic [PW-1:0]                   pll_target_out,
	output logic                            pstate_busy_out
);

	localparam int NT = NCORE * NTHR;

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	// Legacy level one is C1 and levels two to seven follow the idle ladder.
	function automatic logic [3:0] cisr_lvl_map(input logic [3:0] lvl);
		case (lvl)
			4'h2:    cisr_lvl_map = CISR_C3;
			4'h3:    cisr_lvl_map = CISR_C6;
			4'h4:    cisr_lvl_map = CISR_C7;
			4'h5:    cisr_lvl_map = CISR_C8;
			4'h6:    cisr_lvl_map = CISR_C9;
			4'h7:    cisr_lvl_map = CISR_C10;
			default: cisr_lvl_map = CISR_C1;
		endcase
	endfunction : cisr_lvl_map

	function automatic logic [3:0] cisr_min(input logic [3:0] a, input logic [3:0] b);
		cisr_min = (a < b) ? a : b;
	endfunction : cisr_min

	// -----------------------------------------------------------------
	// Configuration registers
	// -----------------------------------------------------------------
	logic [31:0] cfg;
	logic [15:0] cap_lo;
	logic [15:0] cap_hi;
	logic [PW-1:0] sw_preq [NCORE];
	logic [7:0]  dem_cnt [NCORE];
	logic [NCORE-1:0] dem_flag;

	wire redir_en = cfg[CISR_CFG_REDIR];
	wire dem3_en  = cfg[CISR_CFG_DEM3];
	wire dem1_en  = cfg[CISR_CFG_DEM1];
	wire brk_if   = cfg[CISR_CFG_BRKIF];

	// Demotion is off out of reset; firmware turns it on through this word.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cfg    <= CISR_CFG_RST;
			cap_lo <= CISR_CAP_LO_RST;
			cap_hi <= CISR_CAP_HI_RST;
		end else if (reg_wr_in) begin
			if (reg_addr_in == CISR_REG_CFG)
				cfg <= reg_wdata_in;
			if (reg_addr_in == CISR_REG_CAP_LO)
				cap_lo <= reg_wdata_in[15:0];
			if (reg_addr_in == CISR_REG_CAP_HI)
				cap_hi <= reg_wdata_in[15:0];
		end
	end

	// -----------------------------------------------------------------
	// Thread request decode
	// -----------------------------------------------------------------
	logic [3:0]    thr_req [NT];
	logic [NT-1:0] thr_idle;
	logic [NT-1:0] thr_force_brk;
	logic [NT-1:0] thr_trap;

	// A trapped legacy read never reaches the system; anything else passes.
	always_comb begin
		for (int t = 0; t < NT; t++) begin
			thr_trap[t] = redir_en && treq_in[t].io_rd &&
			              treq_in[t].io_addr >= cap_lo && treq_in[t].io_addr <= cap_hi;
			io_pass_out[t] = treq_in[t].io_rd && !thr_trap[t];
			thr_force_brk[t] = thr_trap[t] && brk_if;
			if (thr_trap[t])
				thr_req[t] = cisr_lvl_map(treq_in[t].io_addr[3:0] - cap_lo[3:0] + 4'h1);
			else if (treq_in[t].wait_req)
				thr_req[t] = treq_in[t].wait_level;
			else if (treq_in[t].halt_req)
				thr_req[t] = CISR_C1;
			else
				thr_req[t] = CISR_C0;
			thr_idle[t] = thr_req[t] != CISR_C0;
		end
	end

	// Thread sleep state; a thread leaves only through a wake event.
	logic [3:0]    thr_st [NT];
	logic [NT-1:0] thr_brkif;
	logic [NT-1:0] thr_was_wait;
	logic [NT-1:0] wake;

	always_comb begin
		for (int t = 0; t < NT; t++) begin
			wake[t] = (thr_st[t] != CISR_C0) &&
			          ((thr_irq_in[t] && (!thr_irq_masked_in[t] || thr_brkif[t])) ||
			           pkg_irq_in ||
			           (monitor_hit_in[t] && thr_was_wait[t]) ||
			           deadline_in[t]);
			thr_wake_out[t] = wake[t];
		end
	end

	// A sleeping thread must come back to C0 before taking a new state.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int t = 0; t < NT; t++)
				thr_st[t] <= CISR_C0;
			thr_brkif    <= '0;
			thr_was_wait <= '0;
		end else begin
			for (int t = 0; t < NT; t++) begin
				if (wake[t]) begin
					thr_st[t] <= CISR_C0;
				end else if (thr_st[t] == CISR_C0 && thr_idle[t]) begin
					thr_st[t]       <= thr_req[t];
					thr_brkif[t]    <= thr_force_brk[t];
					thr_was_wait[t] <= treq_in[t].wait_req && !thr_trap[t];
				end
			end
		end
	end

	// -----------------------------------------------------------------
	// Core resolution and demotion
	// -----------------------------------------------------------------
	logic [3:0]       core_req [NCORE];
	logic [3:0]       core_res [NCORE];
	logic [NCORE-1:0] core_idle;

	// Resolution is a minimum over threads, so one active thread wins.
	always_comb begin
		for (int c = 0; c < NCORE; c++) begin
			core_req[c] = CISR_C10;
			for (int j = 0; j < NTHR; j++)
				core_req[c] = cisr_min(core_req[c], thr_st[c*NTHR+j]);
			core_idle[c] = core_req[c] != CISR_C0;
		end
	end

	// Interrupt count per residency window drives demotion decisions.
	logic [$clog2(CISR_RESID_WIN_CYC+1)-1:0] win_cnt;
	logic [7:0] irq_cnt [NCORE];
	wire win_end = win_cnt == ($bits(win_cnt))'(CISR_RESID_WIN_CYC - 1);

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			win_cnt <= '0;
			for (int c = 0; c < NCORE; c++) begin
				irq_cnt[c] <= '0;
				dem_cnt[c] <= '0;
			end
		end else begin
			win_cnt <= win_end ? '0 : win_cnt + 1'b1;
			for (int c = 0; c < NCORE; c++) begin
				if (win_end) begin
					dem_cnt[c] <= irq_cnt[c];
					irq_cnt[c] <= '0;
				end else if ((|thr_irq_in[c*NTHR +: NTHR] || pkg_irq_in) && irq_cnt[c] != 8'hff) begin
					irq_cnt[c] <= irq_cnt[c] + 8'h01;
				end
			end
		end
	end

	// C1 demotion is tested first, against cfg[31:24]; C3 demotion uses cfg[23:16].
	always_comb begin
		for (int c = 0; c < NCORE; c++) begin
			core_res[c] = core_req[c];
			dem_flag[c] = 1'b0;
			if (dem1_en && core_req[c] >= CISR_C3 && dem_cnt[c] >= cfg[31:24]) begin
				core_res[c] = CISR_C1;
				dem_flag[c] = 1'b1;
			end else if (dem3_en && core_req[c] >= CISR_C6 && dem_cnt[c] >= cfg[23:16]) begin
				core_res[c] = CISR_C3;
				dem_flag[c] = 1'b1;
			end
		end
	end

	// -----------------------------------------------------------------
	// Per-core power sequencer
	// -----------------------------------------------------------------
	cisr_seq_t  seq [NCORE];
	logic [3:0] core_st [NCORE];

	// Deep states share one save/power path, so C7 to C10 act as C6.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int c = 0; c < NCORE; c++) begin
				seq[c]     <= CISR_SQ_RUN;
				core_st[c] <= CISR_C0;
			end
		end else begin
			for (int c = 0; c < NCORE; c++) begin
				case (seq[c])
					CISR_SQ_RUN: begin
						if (!core_idle[c]) begin
							core_st[c] <= CISR_C0;
						end else if (core_st[c] == CISR_C0) begin
							core_st[c] <= core_res[c];
							if (core_res[c] == CISR_C3)
								seq[c] <= CISR_SQ_FLUSH;
							else if (core_res[c] >= CISR_C6)
								seq[c] <= CISR_SQ_SAVE;
						end
					end
					CISR_SQ_FLUSH: begin
						if (flush_done_in[c])
							seq[c] <= CISR_SQ_SLEEP;
					end
					CISR_SQ_SAVE: begin
						if (save_done_in[c])
							seq[c] <= CISR_SQ_SLEEP;
					end
					CISR_SQ_SLEEP: begin
						if (!core_idle[c])
							seq[c] <= (core_st[c] >= CISR_C6) ? CISR_SQ_PWRUP : CISR_SQ_RUN;
						if (!core_idle[c] && core_st[c] < CISR_C6)
							core_st[c] <= CISR_C0;
					end
					CISR_SQ_PWRUP: begin
						if (pwr_good_in[c])
							seq[c] <= CISR_SQ_RESTOR;
					end
					CISR_SQ_RESTOR: begin
						if (restore_done_in[c]) begin
							seq[c]     <= CISR_SQ_RUN;
							core_st[c] <= CISR_C0;
						end
					end
					default: seq[c] <= CISR_SQ_RUN;
				endcase
			end
		end
	end

	// Sequencer outputs; snoops only reach a core that is running or in C1.
	always_comb begin
		for (int c = 0; c < NCORE; c++) begin
			core_state_out[c*4 +: 4] = core_st[c];
			flush_req_out[c]   = seq[c] == CISR_SQ_FLUSH;
			save_req_out[c]    = seq[c] == CISR_SQ_SAVE;
			restore_req_out[c] = seq[c] == CISR_SQ_RESTOR;
			clk_stop_out[c]    = seq[c] == CISR_SQ_SLEEP || seq[c] == CISR_SQ_SAVE;
			pwr_off_out[c]     = seq[c] == CISR_SQ_SLEEP && core_st[c] >= CISR_C6;
			snoop_ack_out[c]   = snoop_in[c] && core_st[c] <= CISR_C1;
		end
	end

	// -----------------------------------------------------------------
	// Shared performance state
	// -----------------------------------------------------------------
	logic [PW-1:0] p_want;
	logic [PW-1:0] p_cur;
	logic [PW-1:0] p_tgt;
	cisr_pst_t     pst;

	// Only running cores vote; the fastest request wins.
	always_comb begin
		p_want = '0;
		for (int c = 0; c < NCORE; c++)
			if (!core_idle[c] && sw_preq[c] > p_want)
				p_want = sw_preq[c];
		if (!(|(~core_idle)))
			p_want = p_cur;
	end

	// Requests are stored at once but a new target waits for the idle state.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pst   <= CISR_PS_IDLE;
			p_cur <= '0;
			p_tgt <= '0;
			for (int c = 0; c < NCORE; c++)
				sw_preq[c] <= '0;
		end else begin
			for (int c = 0; c < NCORE; c++)
				if (reg_wr_in && reg_addr_in == CISR_REG_PREQ && reg_wdata_in[8 +: 4] == 4'(c))
					sw_preq[c] <= reg_wdata_in[PW-1:0];
			case (pst)
				CISR_PS_IDLE: begin
					if (p_want != p_cur) begin
						p_tgt <= p_want;
						pst   <= CISR_PS_VOLT;
					end
				end
				CISR_PS_VOLT: begin
					if (volt_ok_in)
						pst <= CISR_PS_LOCK;
				end
				CISR_PS_LOCK: begin
					if (pll_lock_in) begin
						p_cur <= p_tgt;
						pst   <= CISR_PS_IDLE;
					end
				end
				default: pst <= CISR_PS_IDLE;
			endcase
		end
	end

	// Voltage leads; the PLL keeps the old target until voltage is good.
	assign volt_target_out = (pst == CISR_PS_IDLE) ? p_cur : p_tgt;
	assign pll_target_out  = (pst == CISR_PS_LOCK) ? p_tgt : p_cur;
	assign pstate_busy_out = pst != CISR_PS_IDLE;

	// -----------------------------------------------------------------
	// Register read port
	// -----------------------------------------------------------------
	logic [31:0] status_w;
	always_comb begin
		status_w = '0;
		for (int c = 0; c < NCORE && c < 8; c++)
			status_w[c*4 +: 4] = core_st[c];
	end

	logic [31:0] next_rdata;
	always_comb begin
		case (reg_addr_in)
			CISR_REG_CFG:     next_rdata = cfg;
			CISR_REG_CAP_LO:  next_rdata = {16'h0000, cap_lo};
			CISR_REG_CAP_HI:  next_rdata = {16'h0000, cap_hi};
			CISR_REG_PREQ:    next_rdata = 32'(p_cur);
			CISR_REG_STATUS:  next_rdata = status_w;
			CISR_REG_PSTATUS: next_rdata = {30'h0, pst};
			CISR_REG_DEMOTE:  next_rdata = 32'(dem_flag);
			default:          next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			reg_rdata_out <= '0;
		else
			reg_rdata_out <= reg_rd_in ? next_rdata : 32'h0000_0000;
	end

endmodule : cisr_core_idle_state_resolver

/* verif/cisr_core_model.sv */
`timescale 1ns/1ns
// ---------------------------------
// Core, regulator and PLL responder
// ---------------------------------
module cisr_core_model #(
	parameter int NCORE = 2,
	parameter int PW    = 4
) (
	input  wire logic             core_clk_in,
	input  wire logic             arst_n_in,
	input  wire logic [3:0]       dly_in,
	input  wire logic [NCORE-1:0] flush_req_in,
	input  wire logic [NCORE-1:0] save_req_in,
	input  wire logic [NCORE-1:0] restore_req_in,
	input  wire logic [NCORE-1:0] pwr_off_in,
	input  wire logic [PW-1:0]    volt_target_in,
	input  wire logic [PW-1:0]    pll_target_in,
	output logic [NCORE-1:0]      flush_done_out,
	output logic [NCORE-1:0]      save_done_out,
	output logic [NCORE-1:0]      pwr_good_out,
	output logic [NCORE-1:0]      restore_done_out,
	output logic                  volt_ok_out,
	output logic                  pll_lock_out
);
	localparam int N = NCORE * 4 + 2;
	logic [N-1:0]  cond;
	logic [N-1:0]  done;
	logic [3:0]    cnt [N];
	logic [PW-1:0] v_prev;
	logic [PW-1:0] p_prev;

	// A new target restarts the settle count, so a stale ok never answers a fresh step.
	assign cond = {volt_target_in == v_prev, pll_target_in == p_prev, ~pwr_off_in, restore_req_in, save_req_in,
		flush_req_in};
	assign {volt_ok_out, pll_lock_out, pwr_good_out, restore_done_out, save_done_out, flush_done_out} = done;

	// Each answer comes dly_in cycles after its cause, volt_ok_out and pll_lock_out one cycle later; supply is never reported good while off.
	always_comb begin
		for (int i = 0; i < N; i++)
			done[i] = cond[i] && (cnt[i] >= dly_in);
	end

	// Settle counters saturate so a long idle spell cannot wrap them.
	always_ff @(posedge core_clk_in) begin
		v_prev <= volt_target_in;
		p_prev <= pll_target_in;
		for (int i = 0; i < N; i++)
			cnt[i] <= (cond[i] && arst_n_in) ? cnt[i] + {3'h0, cnt[i] != 4'hf} : 4'h0;
	end
endmodule : cisr_core_model

/* verif/cisr_checker.sv */
`timescale 1ns/1ns
// ------------------------
// Port checks on core zero
// ------------------------
module cisr_checker
	import cisr_pkg::*;
#(
	parameter int NCORE = 2,
	parameter int NTHR  = 2,
	parameter int PW    = 4
) (
	input wire logic                        core_clk_in,
	input wire logic                        arst_n_in,
	input wire cisr_treq_t [NCORE*NTHR-1:0] treq_in,
	input wire logic [NCORE*NTHR-1:0]       thr_irq_in,
	input wire logic [NCORE*NTHR-1:0]       thr_irq_masked_in,
	input wire logic [NCORE*NTHR-1:0]       monitor_hit_in,
	input wire logic [NCORE*NTHR-1:0]       deadline_in,
	input wire logic                        pkg_irq_in,
	input wire logic [NCORE-1:0]            snoop_in,
	input wire logic [NCORE-1:0]            flush_done_in,
	input wire logic [NCORE-1:0]            save_done_in,
	input wire logic [NCORE-1:0]            pwr_good_in,
	input wire logic                        volt_ok_in,
	input wire logic [NCORE*NTHR-1:0]       io_pass_out,
	input wire logic [NCORE*NTHR-1:0]       thr_wake_out,
	input wire logic [NCORE*4-1:0]          core_state_out,
	input wire logic [NCORE-1:0]            restore_req_out,
	input wire logic [NCORE-1:0]            clk_stop_out,
	input wire logic [NCORE-1:0]            pwr_off_out,
	input wire logic [NCORE-1:0]            snoop_ack_out,
	input wire logic [PW-1:0]               volt_target_out,
	input wire logic [PW-1:0]               pll_target_out,
	input wire logic                        pstate_busy_out
);
	logic [3:0] st;

	// Core zero stands for all cores; the random loop picks either core, the legacy tests run on core zero and the halt test on core one.
	assign st = core_state_out[3:0];

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!arst_n_in);

	a_legal_level: assert property (st inside {4'h0, 4'h1, 4'h3, [4'h6:4'ha]})
		else $error("core state holds an undefined level");
	a_snoop_in_c1: assert property (snoop_ack_out[0] == (snoop_in[0] && st <= 4'h1))
		else $error("snoop answer does not follow snoop and shallow state");
	a_c3_no_wake: assert property (st == 4'h3 && !pkg_irq_in && {thr_irq_in[1:0], thr_irq_masked_in[1:0],
		monitor_hit_in[1:0], deadline_in[1:0]} == 8'h00 |-> thr_wake_out[1:0] == 2'b00)
		else $error("core in C3 woke without a wake cause");
	a_wake_to_c0: assert property (thr_wake_out[0] |-> ##[1:100] st == 4'h0)
		else $error("woken thread did not bring its core to C0");
	a_stop_after_flush: assert property ($rose(clk_stop_out[0]) && st == 4'h3 |-> $past(flush_done_in[0]))
		else $error("clocks stopped before the flush finished");
	a_off_after_save: assert property ($rose(pwr_off_out[0]) |-> $past(save_done_in[0]))
		else $error("voltage removed before the state was saved");
	a_restore_after_pg: assert property ($rose(restore_req_out[0]) |-> $past(pwr_good_in[0]))
		else $error("restore started before power was good");
	a_pll_after_volt: assert property ($changed(pll_target_out) |-> $past(volt_ok_in))
		else $error("PLL target moved before voltage settled");
	a_volt_in_busy: assert property ($changed(volt_target_out) |-> pstate_busy_out)
		else $error("voltage target moved outside a transition");
	a_io_pass_read: assert property (io_pass_out[0] |-> treq_in[0].io_rd)
		else $error("I/O cycle issued without a read");
endmodule : cisr_checker

bind cisr_core_idle_state_resolver cisr_checker #(.NCORE(NCORE), .NTHR(NTHR), .PW(PW)) i_cisr_checker (
	.core_clk_in, .arst_n_in, .treq_in, .thr_irq_in, .thr_irq_masked_in, .monitor_hit_in, .deadline_in,
	.pkg_irq_in, .snoop_in, .flush_done_in, .save_done_in, .pwr_good_in, .volt_ok_in, .io_pass_out,
	.thr_wake_out, .core_state_out, .restore_req_out, .clk_stop_out, .pwr_off_out, .snoop_ack_out,
	.volt_target_out, .pll_target_out, .pstate_busy_out);

/* verif/cisr_core_idle_state_resolver_tb.sv */
`timescale 1ns/1ns
module cisr_core_idle_state_resolver_tb import cisr_pkg::*;;
	localparam cisr_treq_t HQ = 23'h20000;
	logic             clk, rst_n, rd, wr, pkg, vok, plk, busy, iop;
	logic [1:0]       snp, fd, sd, pg, rdn, fr, sr, rr, cs, po, sa;
	logic [3:0]       irq, msk, mon, ddl, io, wake, wk, dly, addr, vt, pt, e, l0, l1, m;
	logic [7:0]       st;
	logic [31:0]      wd, rdat;
	cisr_treq_t [3:0] treq;
	int               n_errors, checks, k, c;
	logic [3:0]       lv [7] = '{4'h1, 4'h3, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};

	cisr_core_idle_state_resolver #(.NCORE(2), .NTHR(2), .PW(4)) i_cisr_core_idle_state_resolver (
		.core_clk_in(clk), .arst_n_in(rst_n), .treq_in(treq), .thr_irq_in(irq), .thr_irq_masked_in(msk),
		.monitor_hit_in(mon), .deadline_in(ddl), .pkg_irq_in(pkg), .snoop_in(snp), .flush_done_in(fd),
		.save_done_in(sd), .pwr_good_in(pg), .restore_done_in(rdn), .volt_ok_in(vok), .pll_lock_in(plk),
		.reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
		.io_pass_out(io), .thr_wake_out(wake), .core_state_out(st), .flush_req_out(fr), .save_req_out(sr),
		.restore_req_out(rr), .clk_stop_out(cs), .pwr_off_out(po), .snoop_ack_out(sa), .volt_target_out(vt),
		.pll_target_out(pt), .pstate_busy_out(busy));
	cisr_core_model #(.NCORE(2), .PW(4)) i_cisr_core_model (.core_clk_in(clk), .arst_n_in(rst_n), .dly_in(dly),
		.flush_req_in(fr), .save_req_in(sr), .restore_req_in(rr), .pwr_off_in(po), .volt_target_in(vt),
		.pll_target_in(pt), .flush_done_out(fd), .save_done_out(sd), .pwr_good_out(pg), .restore_done_out(rdn),
		.volt_ok_out(vok), .pll_lock_out(plk));

	// Clock, and wake pulses gathered mid-cycle where the combinational pulse has settled.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(negedge clk) wk <= wk | wake;

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, x, s);
		end
	endtask : chk
	task automatic stop_test;
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	// Expected idle level of a legacy read at offset n-1 within the capture range.
	function automatic logic [3:0] leg(input int n);
		return (n == 1) ? 4'h1 : (n == 2) ? 4'h3 : 4'(n + 3);
	endfunction : leg
	function automatic cisr_treq_t wq(input logic [3:0] l);
		return {1'b1, l, 18'h0};
	endfunction : wq
	function automatic cisr_treq_t iq(input logic [15:0] a);
		return {7'h1, a};
	endfunction : iq
	task automatic wrr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrr
	// Read data stand only in the cycle after the strobe, so they are taken at its middle.
	task automatic rdc(input logic [3:0] a, input logic [31:0] x);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("reg_rdata", rdat, x);
	endtask : rdc
	// A thread request lasts one cycle; the I/O pass-through is sampled while it stands.
	task automatic tq(input int t, input cisr_treq_t v);
		@(posedge clk);
		treq[t] <= v;
		@(negedge clk);
		iop = io[t];
		@(posedge clk);
		treq[t] <= '0;
	endtask : tq
	task automatic pulse(input int kind, input logic [3:0] v);
		@(posedge clk);
		case (kind)
			0: irq <= v;
			1: mon <= v;
			2: ddl <= v;
			3: pkg <= 1'b1;
			default: {irq, msk} <= {v, v};
		endcase
		@(posedge clk);
		{irq, mon, ddl, msk, pkg} <= '0;
	endtask : pulse
	task automatic ws(input int cc, input logic [3:0] x);
		for (int i = 0; i < 300 && st[cc*4+:4] !== x; i++)
			@(posedge clk);
		#1;
		chk("core_state", st[cc*4+:4], x);
	endtask : ws

	// Hang guard sized well beyond the expected few thousand cycles.
	initial begin
		#800000;
		n_errors++;
		stop_test();
	end

	// -------------
	// Main sequence
	// -------------
	initial begin
		{rst_n, rd, wr, pkg, snp, irq, msk, mon, ddl, addr, wd, wk} = '0;
		treq = '0;
		dly = 4'h2;
		n_errors = 0;
		checks = 0;
		void'($urandom(32'hb780));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rdc(CISR_REG_CFG, CISR_CFG_RST);
		rdc(4'hf, 32'h0);
		chk("core_state", st, 8'h00);
		// Random depths on both threads of a core, then a random wake cause.
		for (int n = 0; n < 16; n++) begin
			c = $urandom % 2;
			l0 = lv[$urandom % 7];
			l1 = lv[$urandom % 7];
			dly <= 4'($urandom % 7);
			tq(c * 2, wq(l0));
			repeat (3) @(posedge clk);
			chk("core_state", st[c*4+:4], 4'h0);
			tq(c * 2 + 1, wq(l1));
			e = (l0 < l1) ? l0 : l1;
			ws(c, e);
			repeat (20) @(posedge clk);
			chk("clk_stop", cs[c], e >= 4'h3);
			chk("pwr_off", po[c], e >= 4'h6);
			wk = '0;
			snp[c] <= 1'b1;
			repeat (3) @(posedge clk);
			snp[c] <= 1'b0;
			chk("snoop_ack", sa[c], e == 4'h1);
			chk("thr_wake", wk, 4'h0);
			k = $urandom % 4;
			m = 4'h1 << (c * 2 + $urandom % 2);
			pulse(k, m);
			repeat (2) @(posedge clk);
			chk("thr_wake", wk, (k == 3) ? (4'h3 << (c * 2)) : m);
			ws(c, 4'h0);
			pulse(3, 4'h0);
			repeat (3) @(posedge clk);
		end
		// A halted core ignores a deeper request until it has passed through C0.
		tq(2, HQ);
		tq(3, HQ);
		ws(1, 4'h1);
		tq(2, wq(4'h6));
		tq(3, wq(4'h6));
		repeat (10) @(posedge clk);
		chk("core_state", st[7:4], 4'h1);
		pulse(3, 4'h0);
		ws(1, 4'h0);
		// Every legacy level inside the capture range, woken by a masked interrupt.
		wrr(CISR_REG_CAP_LO, 32'h10);
		wrr(CISR_REG_CAP_HI, 32'h16);
		for (int j = 1; j <= 7; j++) begin
			tq(0, iq(16'(15 + j)));
			chk("io_pass", iop, 1'b0);
			tq(1, iq(16'(15 + j)));
			ws(0, leg(j));
			rdc(CISR_REG_STATUS, 32'(leg(j)));
			pulse(4, 4'h3);
			ws(0, 4'h0);
		end
		tq(0, iq(16'h20));
		chk("io_pass", iop, 1'b1);
		tq(1, HQ);
		repeat (4) @(posedge clk);
		chk("core_state", st[3:0], 4'h0);
		pulse(3, 4'h0);
		wrr(CISR_REG_CFG, 32'h8);
		tq(0, iq(16'h10));
		chk("io_pass", iop, 1'b1);
		// A second step requested mid-transition is deferred, then the highest level wins.
		dly <= 4'h5;
		wrr(CISR_REG_PREQ, 32'h003);
		wrr(CISR_REG_PREQ, 32'h109);
		repeat (80) @(posedge clk);
		chk("volt_target", vt, 4'h9);
		chk("pll_target", pt, 4'h9);
		wrr(CISR_REG_PREQ, 32'h102);
		repeat (80) @(posedge clk);
		chk("volt_target", vt, 4'h3);
		// Reset in mid-sleep clears cores and configuration.
		tq(0, wq(4'h3));
		tq(1, wq(4'h3));
		ws(0, 4'h3);
		repeat (10) @(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		#1;
		chk("core_state", st, 8'h00);
		@(posedge clk);
		rst_n <= 1'b1;
		rdc(CISR_REG_CFG, CISR_CFG_RST);
		stop_test();
	end
endmodule : cisr_core_idle_state_resolver_tb
